// File: rtl/flash_half_ctrl.sv
// Mode decode for one half of the flash array
module flash_half_ctrl
	import flash_seq_pkg::*;
(
	input  wire logic [CTRL_W-1:0] ctrl,
	input  wire logic              flash_write_enable_pin,
	input  wire logic              blockSel,
	output logic                   progOn,
	output logic                   eraseOn,
	output logic                   progSetup,
	output logic                   eraseSetup
);
	logic armed;

	// Nothing reaches the cells while the enable pin is low
	assign armed      = flash_write_enable_pin & ctrl[BIT_SWE]; // RULE24
	assign progSetup  = armed & ctrl[BIT_PSU];
	assign eraseSetup = armed & ctrl[BIT_ESU];
	assign progOn     = progSetup & ctrl[BIT_P]; // RULE23
	assign eraseOn    = eraseSetup & ctrl[BIT_E] & blockSel;
endmodule

// File: rtl/flash_program_erase_verify_seq.sv
// Flash program, erase and verify sequencer with APB register access
// What the document requires
// RULE1 - Software clears pulse bits, waits hold time, then clears setup bits.
// RULE2 - Watchdog setting is cancelled automatically when program mode is left.
// RULE3 - Program-verify mode is entered when both verify bits are set.
// RULE4 - Software dummy-writes all-ones before each verify read, after setup time.
// RULE5 - Verify reads return the 16-bit word at the dummy-write address.
// RULE6 - After 128 bytes verified, software leaves verify mode and waits.
// RULE7 - Software repeats program and verify up to the maximum count.
// RULE8 - Software waits the hold time after clearing a write-enable bit.
// RULE9 - A programming unit is 128 bytes starting at low byte 00 or 80.
// RULE10 - Software writes all 128 bytes consecutively, padding with all-ones.
// RULE11 - Reprogram data is source OR NOT verify, per bit.
// RULE12 - Additional-programming data is loop reprogram data OR verify, per bit.
// RULE13 - Additional programming only in loops one to six, newly zero bits.
// RULE14 - Pulse width 30 early, 200 from loop seven, 10 when additional.
// RULE15 - A programmed bit later reading one gets another pulse.
// RULE16 - A finished unit gets no further pulses until it is erased.
// RULE17 - Software selects exactly one erase block after write-enable setup time.
// RULE18 - Software arms the watchdog longer than erase time plus margins.
// RULE19 - Software sets erase setup, then erase, holding it no longer than allowed.
// RULE20 - Erase mode left by clearing erase then setup; watchdog setting cancelled.
// RULE21 - Erase verify checks each word for all-ones, re-erasing up to limit.
// RULE22 - Software exits erase verify, moves to next block, then clears enables.
// RULE23 - Program mode is setup bits, then pulse bits; pulse time programs.
// RULE24 - No programming or erasing while the write-enable pin is low.
// RULE25 - Software counts loops and reports failure at the count limit.
//
// Decided for this implementation: the APB slave port and the register addresses.
module flash_program_erase_verify_seq
	import flash_seq_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic [31:0]            prdata,
	input  wire logic              flashWriteEnablePin,
	input  wire logic [15:0]       arrRdData,
	output logic [ADDR_W-1:0]      arrAddr,
	output logic [7:0]             arrWrData,
	output logic                   arrWrEn,
	output logic [1:0]             arrProg,
	output logic [1:0]             arrErase,
	output logic                   arrVerify,
	output logic [2*EBR_W-1:0]     arrBlockSel,
	output logic                   wdArmed,
	output logic                   wdCancel
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [CTRL_W-1:0] ctrlLower;
		logic [CTRL_W-1:0] ctrlUpper;
		logic [EBR_W-1:0]  ebrLower;
		logic [EBR_W-1:0]  ebrUpper;
		logic [ADDR_W-1:0] addr;
		logic              wdArm;
		logic              wdCancel;
		logic              progSetupAny;
		logic              eraseSetupAny;
		mode_t             mode;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
		logic [ADDR_W-1:0] arrAddr;
		logic [7:0]        arrWrData;
		logic              arrWrEn;
		logic [1:0]        arrProg;
		logic [1:0]        arrErase;
		logic              arrVerify;
	} state_t;

	state_t q;
	state_t d;

	logic progOnL, eraseOnL, progSetupL, eraseSetupL;
	logic progOnU, eraseOnU, progSetupU, eraseSetupU;
	logic progVerify, eraseVerify, access;

	// ----------------------------------------
	// Per-half decode
	// ----------------------------------------
	flash_half_ctrl lowerHalf (
		.ctrl       (q.ctrlLower),
		.flash_write_enable_pin        (flashWriteEnablePin),
		.blockSel   (|q.ebrLower),
		.progOn     (progOnL),
		.eraseOn    (eraseOnL),
		.progSetup  (progSetupL),
		.eraseSetup (eraseSetupL)
	);

	flash_half_ctrl upperHalf (
		.ctrl       (q.ctrlUpper),
		.flash_write_enable_pin        (flashWriteEnablePin),
		.blockSel   (|q.ebrUpper),
		.progOn     (progOnU),
		.eraseOn    (eraseOnU),
		.progSetup  (progSetupU),
		.eraseSetup (eraseSetupU)
	);

	// Verify needs the bit in both registers
	assign progVerify  = q.ctrlLower[BIT_PV] & q.ctrlUpper[BIT_PV]; // RULE3
	assign eraseVerify = q.ctrlLower[BIT_EV] & q.ctrlUpper[BIT_EV];
	assign access      = psel & penable & ~q.pready;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.pready   = 1'b0;
		d.pslverr  = 1'b0;
		d.arrWrEn  = 1'b0;
		d.wdCancel = 1'b0;

		// Mode follows the control bits, pulses first
		d.progSetupAny  = progSetupL | progSetupU;
		d.eraseSetupAny = eraseSetupL | eraseSetupU;
		if (progOnL | progOnU) begin
			d.mode = MODE_PROG; // RULE23
		end else if (eraseOnL | eraseOnU) begin
			d.mode = MODE_ERASE;
		end else if (progSetupL | progSetupU) begin
			d.mode = MODE_PSETUP;
		end else if (eraseSetupL | eraseSetupU) begin
			d.mode = MODE_ESETUP;
		end else if (progVerify) begin
			d.mode = MODE_PVERIFY; // RULE3
		end else if (eraseVerify) begin
			d.mode = MODE_EVERIFY;
		end else begin
			d.mode = MODE_IDLE;
		end
		d.arrProg   = {progOnU, progOnL};
		d.arrErase  = {eraseOnU, eraseOnL};
		d.arrVerify = progVerify | eraseVerify;

		// Leaving program or erase mode drops the watchdog setting
		if ((q.progSetupAny & ~d.progSetupAny) | (q.eraseSetupAny & ~d.eraseSetupAny)) begin
			d.wdArm    = 1'b0; // RULE2 RULE20
			d.wdCancel = 1'b1;
		end

		if (access) begin
			d.pready = 1'b1;
			if (pwrite) begin
				case (paddr)
					OFS_CTRL_LOWER: d.ctrlLower = pwdata[CTRL_W-1:0];
					OFS_CTRL_UPPER: d.ctrlUpper = pwdata[CTRL_W-1:0];
					OFS_EBR_LOWER:  d.ebrLower = pwdata[EBR_W-1:0];
					OFS_EBR_UPPER:  d.ebrUpper = pwdata[EBR_W-1:0];
					OFS_ADDR:       d.addr = pwdata[ADDR_W-1:0];
					OFS_WDOG:       d.wdArm = pwdata[0];
					OFS_STATUS: begin
					end
					OFS_DATA: begin
						d.arrAddr = q.addr;
						if (q.arrVerify) begin
							// Dummy write only latches the word to check
							d.arrAddr = {q.addr[ADDR_W-1:1], 1'b0}; // RULE5
						end else begin
							// Byte stream into the page latch, address steps
							d.arrWrData = pwdata[7:0];
							d.arrWrEn   = 1'b1;
							d.addr      = q.addr + 19'h00001;
						end
					end
					default: d.pslverr = 1'b1;
				endcase
			end else begin
				case (paddr)
					OFS_CTRL_LOWER: d.prdata = {24'h000000, flashWriteEnablePin, q.ctrlLower};
					OFS_CTRL_UPPER: d.prdata = {24'h000000, flashWriteEnablePin, q.ctrlUpper};
					OFS_EBR_LOWER:  d.prdata = {24'h000000, q.ebrLower};
					OFS_EBR_UPPER:  d.prdata = {24'h000000, q.ebrUpper};
					OFS_ADDR:       d.prdata = {13'h0000, q.addr};
					OFS_WDOG:       d.prdata = {31'h00000000, q.wdArm};
					OFS_STATUS:     d.prdata = {28'h0000000, flashWriteEnablePin, q.mode};
					OFS_DATA: begin
						// Outside verify the array is not readable here
						d.prdata = q.arrVerify ? {16'h0000, arrRdData} : RD_ZERO; // RULE5
					end
					default: begin
						d.prdata  = RD_ZERO;
						d.pslverr = 1'b1;
					end
				endcase
			end
		end

		// Pin low wipes the control and erase-block state, overriding writes to it
		if (!flashWriteEnablePin) begin
			d.ctrlLower = CTRL_RST; // RULE24
			d.ctrlUpper = CTRL_RST;
			d.ebrLower  = EBR_RST;
			d.ebrUpper  = EBR_RST;
			d.arrProg   = 2'h0;
			d.arrErase  = 2'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '{ctrlLower: CTRL_RST, ctrlUpper: CTRL_RST, ebrLower: EBR_RST,
				ebrUpper: EBR_RST, addr: ADDR_RST, mode: MODE_IDLE,
				prdata: RD_ZERO, arrAddr: ADDR_RST, arrWrData: 8'h00,
				arrProg: 2'h0, arrErase: 2'h0, default: 1'b0};
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pready      = q.pready;
	assign pslverr     = q.pslverr;
	assign prdata      = q.prdata;
	assign arrAddr     = q.arrAddr;
	assign arrWrData   = q.arrWrData;
	assign arrWrEn     = q.arrWrEn;
	assign arrProg     = q.arrProg;
	assign arrErase    = q.arrErase;
	assign arrVerify   = q.arrVerify;
	assign arrBlockSel = {q.ebrUpper, q.ebrLower};
	assign wdArmed     = q.wdArm;
	assign wdCancel    = q.wdCancel;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	AST_PROG_EXIT_WD: assert property ( // RULE2
		$fell(q.progSetupAny) |-> !wdArmed && wdCancel ##1 !wdCancel)
		else $error("watchdog not cancelled on program exit");

	AST_ERASE_EXIT_WD: assert property ( // RULE20
		$fell(q.eraseSetupAny) |-> !wdArmed && wdCancel)
		else $error("watchdog not cancelled on erase exit");

	AST_PV_ENTRY: assert property ( // RULE3
		(q.mode == MODE_PVERIFY) |-> arrVerify && $past(progVerify))
		else $error("verify mode without both verify bits");

	AST_VERIFY_READ: assert property ( // RULE5
		access && !pwrite && paddr == OFS_DATA && arrVerify
		|=> pready && prdata[15:0] == $past(arrRdData) && prdata[31:16] == 16'h0000)
		else $error("verify read returned wrong word");

	AST_DUMMY_LATCH: assert property ( // RULE5
		access && pwrite && paddr == OFS_DATA && arrVerify
		|=> arrAddr == {$past(q.addr[ADDR_W-1:1]), 1'b0} && !arrWrEn)
		else $error("dummy write did not latch address");

	AST_PULSE_AFTER_SETUP: assert property ( // RULE23
		arrProg[0] |-> $past(q.ctrlLower[BIT_PSU] && q.ctrlLower[BIT_P]))
		else $error("program pulse without setup and pulse bits");

	AST_FWE_BLOCKS: assert property ( // RULE24
		!flashWriteEnablePin |=> arrProg == 2'h0 && arrErase == 2'h0 && q.ctrlLower == CTRL_RST)
		else $error("program or erase with write-enable pin low");

	COV_PROG: cover property (q.mode == MODE_PSETUP ##[1:50] q.mode == MODE_PROG);
	COV_PV_READ: cover property (access && !pwrite && paddr == OFS_DATA && arrVerify);
	COV_ERASE: cover property (arrErase != 2'h0 ##[1:200] q.mode == MODE_EVERIFY);
endmodule

// File: rtl/flash_seq_pkg.sv
// Constants, register map and types of the flash sequencer
package flash_seq_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ADDR_W = 19;
	localparam int CTRL_W = 7;
	localparam int EBR_W  = 8;
	localparam int HALF_BIT = 18;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL_LOWER = 8'h00;
	localparam logic [7:0] OFS_CTRL_UPPER = 8'h04;
	localparam logic [7:0] OFS_EBR_LOWER  = 8'h08;
	localparam logic [7:0] OFS_EBR_UPPER  = 8'h0c;
	localparam logic [7:0] OFS_ADDR       = 8'h10;
	localparam logic [7:0] OFS_DATA       = 8'h14;
	localparam logic [7:0] OFS_STATUS     = 8'h18;
	localparam logic [7:0] OFS_WDOG       = 8'h1c;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int BIT_P   = 0;
	localparam int BIT_E   = 1;
	localparam int BIT_PV  = 2;
	localparam int BIT_EV  = 3;
	localparam int BIT_PSU = 4;
	localparam int BIT_ESU = 5;
	localparam int BIT_SWE = 6;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
	localparam logic [EBR_W-1:0]  EBR_RST  = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
	localparam logic [31:0]       RD_ZERO  = 32'h00000000;

	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_PSETUP,
		MODE_PROG,
		MODE_PVERIFY,
		MODE_ESETUP,
		MODE_ERASE,
		MODE_EVERIFY
	} mode_t;

endpackage

// File: verification/flash_array_model.sv
// Behavioural flash array: page latch, word read port, bulk erase
module flash_array_model
	import flash_seq_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [ADDR_W-1:0] arrAddr,
	input  wire logic [7:0]        arrWrData,
	input  wire logic              arrWrEn,
	input  wire logic [1:0]        arrProg,
	input  wire logic [1:0]        arrErase,
	output logic      [15:0]       arrRdData,
	output int                     wrCount
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cells [256];
	logic [7:0] latchBuf [256];
	logic [7:0] wordBase;
	initial begin
		wrCount = 0;
		foreach (cells[i]) begin
			cells[i] = 8'hff;
			latchBuf[i] = 8'hff;
		end
	end
	// Only 256 cells: enough for one unit, address wraps above that
	always @(posedge clk) begin
		if (arrWrEn) begin
			latchBuf[arrAddr[7:0]] <= arrWrData;
			wrCount <= wrCount + 1;
		end
		if (|arrProg)
			foreach (cells[i]) cells[i] <= cells[i] & latchBuf[i];
		if (|arrErase)
			foreach (cells[i]) cells[i] <= 8'hff;
	end
	assign wordBase = {arrAddr[7:1], 1'b0};
	assign arrRdData = {cells[wordBase | 8'h01], cells[wordBase]};
endmodule

// File: verification/flash_program_erase_verify_seq_tb.sv
// Self-checking bench for the flash sequencer
module flash_program_erase_verify_seq_tb;
	import flash_seq_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic isRd; logic [31:0] dat; logic err;} note_t;
	logic clk, srst, psel, penable, pwrite, pready, pslverr, pin, arrWrEn;
	logic arrVerify, wdArmed, wdCancel;
	logic [7:0] paddr, arrWrData, d0, d1;
	logic [31:0] pwdata, prdata;
	logic [15:0] arrRdData, arrBlockSel, reprog, extra;
	logic [ADDR_W-1:0] arrAddr;
	logic [1:0] arrProg, arrErase;
	int wrCount, err_total, checks, cancels;
	note_t notes[$];
	note_t cur;

	flash_program_erase_verify_seq flash_program_erase_verify_seq_i (.clk(clk), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .flashWriteEnablePin(pin),
		.arrRdData(arrRdData), .arrAddr(arrAddr), .arrWrData(arrWrData), .arrWrEn(arrWrEn),
		.arrProg(arrProg), .arrErase(arrErase), .arrVerify(arrVerify),
		.arrBlockSel(arrBlockSel), .wdArmed(wdArmed), .wdCancel(wdCancel));
	flash_array_model flash_array_model_i (.clk(clk), .arrAddr(arrAddr),
		.arrWrData(arrWrData), .arrWrEn(arrWrEn), .arrProg(arrProg),
		.arrErase(arrErase), .arrRdData(arrRdData), .wrCount(wrCount));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("MISMATCH t=%0t %s", $time, msg);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] ed, input logic ee);
		int n;
		notes.push_back('{!w, ed, ee});
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (pready !== 1'b1)
			check(1'b0, "no pready");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, e, 1'b0);
	endtask
	task automatic both(input logic [31:0] d);
		wr(OFS_CTRL_LOWER, d);
		wr(OFS_CTRL_UPPER, d);
		repeat (3) @(posedge clk);
	endtask
	task automatic wrap_up();
		repeat (2) @(posedge clk);
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, monitor, watchdog, sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (wdCancel === 1'b1)
			cancels++;
	end
	always @(posedge clk) begin
		if (pready === 1'b1 && notes.size() > 0) begin
			cur = notes.pop_front();
			check(pslverr === cur.err, "pslverr");
			if (cur.isRd)
				check(prdata === cur.dat, "read data");
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		wrap_up();
	end
	initial begin
		srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; pin = 1'b0; err_total = 0; checks = 0; cancels = 0;
		void'($urandom(27835));
		d0 = 8'($urandom());
		d1 = 8'($urandom());
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rd(OFS_STATUS, 32'h0);
		wr(OFS_CTRL_LOWER, 32'h51);
		rd(OFS_CTRL_LOWER, 32'h0);
		check(arrProg === 2'b00, "prog with pin low");
		$display("test pin_low done");
		pin <= 1'b1;
		both(32'h40);
		wr(OFS_ADDR, 32'h80);
		wr(OFS_DATA, {24'h0, d0});
		wr(OFS_DATA, {24'h0, d1});
		both(32'h50);
		check(wrCount == 2, "latch writes");
		rd(OFS_STATUS, 32'h9);
		both(32'h51);
		check(arrProg === 2'b11, "prog pulse");
		wr(OFS_WDOG, 32'h1);
		both(32'h50);
		check(wdArmed === 1'b1 && arrProg === 2'b00, "pulse off");
		both(32'h40);
		check(wdArmed === 1'b0, "watchdog after program");
		rd(OFS_WDOG, 32'h0);
		wr(OFS_CTRL_LOWER, 32'h44);
		repeat (3) @(posedge clk);
		check(arrVerify === 1'b0, "verify one half");
		both(32'h44);
		check(arrVerify === 1'b1, "verify both");
		wr(OFS_ADDR, 32'h81);
		wr(OFS_DATA, 32'hff);
		repeat (3) @(posedge clk);
		check(arrAddr === 19'h80, "dummy write address");
		rd(OFS_DATA, {16'h0, d1, d0});
		reprog = {d1, d0} | ~arrRdData;
		extra = reprog | arrRdData;
		check(reprog === 16'hffff, "reprogram data");
		check(extra === 16'hffff, "additional data");
		$display("test program done");
		both(32'h40);
		wr(OFS_EBR_LOWER, 32'h1);
		wr(OFS_WDOG, 32'h1);
		both(32'h60);
		both(32'h62);
		check(arrErase === 2'b01, "erase one block");
		check(arrBlockSel === 16'h0001, "block select");
		both(32'h60);
		both(32'h40);
		check(wdArmed === 1'b0, "watchdog after erase");
		check(cancels == 2, "cancel pulses");
		both(32'h48);
		wr(OFS_ADDR, 32'h80);
		wr(OFS_DATA, 32'hff);
		rd(OFS_DATA, 32'h0000ffff);
		both(32'h00);
		$display("test erase done");
		apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
		$display("test unmapped done");
		wrap_up();
	end
endmodule
